// >>> shared/tos_defs.svh
// Purpose: Constants for the thermal overload stage decision logic.
// Assumes: Thresholds in 0.1 % units, delay in 5 ms steps, 40 MHz clock.
// Notes: Included by the package and the design files.
`ifndef TOS_DEFS_SVH
`define TOS_DEFS_SVH
`define TOS_THR_W 11
`define TOS_DLY_W 20
`define TOS_CUR_W 16
`define TOS_FIX_W 16
`define TOS_FIX_ONE 16'h0400
`define TOS_FIX_FRAC 10
`define TOS_A1_DEF 11'h190
`define TOS_A2_DEF 11'h190
`define TOS_INH_DEF 11'h320
`define TOS_TRIP_DEF 11'h3E8
`define TOS_THR_MAX 11'h5DC
`define TOS_DLY_MAX 20'hAFC80
`define TOS_STEP_NS 5000000
`define TOS_CLK_NS 25
`define TOS_STEP_CYC (`TOS_STEP_NS / `TOS_CLK_NS)
`define TOS_STEP_CW 18
`define TOS_LIGHT_DIV 7'h64
`define TOS_TWO_SHIFT 1
`endif

// >>> shared/tos_pkg.sv
// Purpose: Types shared by the thermal overload stage files.
// Assumes: tos_defs.svh holds all numeric constants.
// Notes: Settings and status travel as packed structs.
`include "tos_defs.svh"
package tos_pkg;
  typedef enum logic [2:0] {
    TOS_COND_NORMAL = 3'h0,
    TOS_COND_ALARM1 = 3'h1,
    TOS_COND_ALARM2 = 3'h2,
    TOS_COND_INHIBIT = 3'h3,
    TOS_COND_TRIP = 3'h4,
    TOS_COND_BLOCKED = 3'h5
  } tos_cond_e;
  typedef enum logic [1:0] {
    TOS_LOAD_LIGHT = 2'h0,
    TOS_LOAD_NORMAL = 2'h1,
    TOS_LOAD_OVER = 2'h2,
    TOS_LOAD_HIGH = 2'h3
  } tos_load_e;
  typedef enum logic [1:0] {
    TOS_TRIP_IDLE = 2'h0,
    TOS_TRIP_TIMING = 2'h1,
    TOS_TRIP_ACTIVE = 2'h2,
    TOS_TRIP_BLOCKED = 2'h3
  } tos_trip_e;
  typedef struct packed {
    logic alarm1_en;
    logic alarm2_en;
    logic restart_lock_enable;
    logic trip_en;
    logic [`TOS_THR_W-1:0] first_alarm_threshold;
    logic [`TOS_THR_W-1:0] second_alarm_threshold;
    logic [`TOS_THR_W-1:0] restart_lock_threshold;
    logic [`TOS_THR_W-1:0] operate_threshold;
    logic [`TOS_DLY_W-1:0] operate_extra_delay;
  } tos_set_s;
  typedef struct packed {
    logic [`TOS_FIX_W-1:0] service_factor;
    logic [`TOS_FIX_W-1:0] ambient_k;
    logic [`TOS_FIX_W-1:0] nominal_k;
    logic ambient_valid;
    logic ambient_k_consistent;
  } tos_fix_s;
  typedef struct packed {
    logic service_fault;
    logic ambient_fault;
    logic nominal_fault;
    logic ambient_k_fault;
  } tos_fault_s;
  typedef struct packed {
    logic alarm1;
    logic alarm2;
    logic restart_lock;
    logic trip;
    logic start;
    logic blocked;
  } tos_out_s;
endpackage

// >>> hdl/tos_delay.sv
// Purpose: Added operate delay counter in 5 ms steps.
// Assumes: Arm held high while the delay should run.
// Notes: Zero steps gives done in the same cycle as arm.
`timescale 1ns/1ps
`include "tos_defs.svh"
module tos_delay (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Control.
  input wire logic arm,
  input wire logic [`TOS_DLY_W-1:0] steps,
  // Result.
  output logic done
);
  import tos_pkg::*;
  logic [`TOS_STEP_CW-1:0] tick_r;
  logic [`TOS_DLY_W-1:0] step_cnt_r;
  localparam logic [`TOS_STEP_CW-1:0] STEP_LAST = `TOS_STEP_CW'(`TOS_STEP_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // The step count is re-read every cycle, so a new setting group takes effect at once.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_r <= '0;
      step_cnt_r <= '0;
    end else if (!arm) begin
      tick_r <= '0;
      step_cnt_r <= '0;
    end else if (step_cnt_r < steps) begin
      if (tick_r == STEP_LAST) begin
        tick_r <= '0;
        step_cnt_r <= step_cnt_r + `TOS_DLY_W'(1);
      end else begin
        tick_r <= tick_r + `TOS_STEP_CW'(1);
      end
    end
  end

  assign done = arm && (step_cnt_r >= steps);
endmodule

// >>> hdl/tos_stage.sv
// Purpose: Decision stage of the thermal overload stage.
// Assumes: Thermal capacity and current come from the thermal image on sys_clk.
// Notes: One evaluation per program cycle, marked by cycle_start.
//
// What this block does
// RULE1: Outputs depend only on thermal capacity, each against its own threshold.
// RULE2: Alarm 1 asserts at capacity >= threshold, 0.1% steps, default 40%.
// RULE3: Alarm 2 asserts at its own threshold, 0.1% steps, default 40%.
// RULE4: Inhibit default 80%, trip default 100%, all compares greater or equal.
// RULE5: Each output has an enable, default off; disabled never asserts.
// RULE6: Trip waits an added delay in 5 ms steps after threshold.
// RULE7: Zero delay gives trip with no added wait.
// RULE8: New setting group values apply immediately while running.
// RULE9: Blocking input is sampled at each program cycle start.
// RULE10: Pick-up with blocking off asserts start and runs the operate timing; here start is forced low while the condition code is normal.
// RULE11: Pick-up with blocking on asserts blocked and stops processing.
// RULE12: Blocking after start clears start and resets timing like dropout.
// RULE13: Blocking must arrive 5 ms before the delay ends to be sure.
// RULE14: Condition code reports normal, alarm1, alarm2, inhibit, trip or blocked.
// RULE15: With condition normal, every output control is low.
// RULE16: Current below 1% of nominal reports light or no load.
// RULE17: Load normal, overloading and high overload by trip limit and twice nominal.
// RULE18: Invalid service factor uses 1.0 and shows a fault while it lasts.
// RULE19: Invalid ambient settings use 1.0 correction and flag ambient fault.
// RULE20: Invalid nominal current setting uses 1.0 and flags its fault.
// RULE21: Inconsistent ambient k setting shows its own fault while it lasts.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "tos_defs.svh"
module tos_stage (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Program cycle and thermal image.
  input wire logic cycle_start,
  input wire logic [`TOS_THR_W-1:0] thermal_cap,
  input wire logic [`TOS_CUR_W-1:0] meas_current,
  input wire logic [`TOS_CUR_W-1:0] nominal_current,
  // Blocking input from the blocking matrix.
  input wire logic block_in,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Raw correction settings.
  input wire tos_pkg::tos_fix_s fix_raw,
  // Results.
  output tos_pkg::tos_out_s outs,
  output tos_pkg::tos_cond_e operating_condition_code,
  output tos_pkg::tos_load_e load_status,
  output tos_pkg::tos_fault_s setting_fault_flag,
  output tos_pkg::tos_fix_s fix_used
);
  import tos_pkg::*;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_A1 = 4'h1;
  localparam logic [3:0] ADDR_A2 = 4'h2;
  localparam logic [3:0] ADDR_INH = 4'h3;
  localparam logic [3:0] ADDR_TRIP = 4'h4;
  localparam logic [3:0] ADDR_DLY = 4'h5;
  localparam logic [3:0] ADDR_STAT = 4'h6;

  tos_set_s set_r;
  logic blk_meta_r;
  logic blk_sync_r;
  logic blk_r;
  logic [`TOS_THR_W-1:0] cap_r;
  tos_trip_e trip_st_r;
  tos_trip_e trip_st_nxt;
  logic delay_done;
  logic trip_pick;
  logic a1_hit;
  logic a2_hit;
  logic inh_hit;
  tos_out_s outs_nxt;
  tos_cond_e cond_nxt;
  tos_load_e load_nxt;
  tos_fault_s fault_nxt;
  tos_fix_s fix_nxt;
  logic [`TOS_CUR_W+6:0] cur_x100;
  logic [`TOS_CUR_W:0] nom_x2;
  logic [`TOS_CUR_W-1:0] trip_limit;

  ////////////////////////////////////////////////////////////////////////////
  // Register writes. Settings are used the very next cycle, no shadow copy.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      set_r.alarm1_en <= 1'b0; // RULE5
      set_r.alarm2_en <= 1'b0;
      set_r.restart_lock_enable <= 1'b0;
      set_r.trip_en <= 1'b0;
      set_r.first_alarm_threshold <= `TOS_A1_DEF; // RULE2
      set_r.second_alarm_threshold <= `TOS_A2_DEF; // RULE3
      set_r.restart_lock_threshold <= `TOS_INH_DEF; // RULE4
      set_r.operate_threshold <= `TOS_TRIP_DEF; // RULE4
      set_r.operate_extra_delay <= '0; // RULE7
    end else if (reg_wr) begin // RULE8
      case (reg_addr)
        ADDR_CTRL: begin
          set_r.alarm1_en <= reg_wdata[0];
          set_r.alarm2_en <= reg_wdata[1];
          set_r.restart_lock_enable <= reg_wdata[2];
          set_r.trip_en <= reg_wdata[3];
        end
        ADDR_A1: begin
          if (reg_wdata[`TOS_THR_W-1:0] <= `TOS_THR_MAX) begin
            set_r.first_alarm_threshold <= reg_wdata[`TOS_THR_W-1:0];
          end
        end
        ADDR_A2: begin
          if (reg_wdata[`TOS_THR_W-1:0] <= `TOS_THR_MAX) begin
            set_r.second_alarm_threshold <= reg_wdata[`TOS_THR_W-1:0];
          end
        end
        ADDR_INH: begin
          if (reg_wdata[`TOS_THR_W-1:0] <= `TOS_THR_MAX) begin
            set_r.restart_lock_threshold <= reg_wdata[`TOS_THR_W-1:0];
          end
        end
        ADDR_TRIP: begin
          if (reg_wdata[`TOS_THR_W-1:0] <= `TOS_THR_MAX) begin
            set_r.operate_threshold <= reg_wdata[`TOS_THR_W-1:0];
          end
        end
        ADDR_DLY: begin
          if (reg_wdata[`TOS_DLY_W-1:0] <= `TOS_DLY_MAX) begin
            set_r.operate_extra_delay <= reg_wdata[`TOS_DLY_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, data one cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= {28'h0000000, set_r.trip_en, set_r.restart_lock_enable,
                                 set_r.alarm2_en, set_r.alarm1_en};
        ADDR_A1: reg_rdata <= {21'h000000, set_r.first_alarm_threshold};
        ADDR_A2: reg_rdata <= {21'h000000, set_r.second_alarm_threshold};
        ADDR_INH: reg_rdata <= {21'h000000, set_r.restart_lock_threshold};
        ADDR_TRIP: reg_rdata <= {21'h000000, set_r.operate_threshold};
        ADDR_DLY: reg_rdata <= {12'h000, set_r.operate_extra_delay};
        ADDR_STAT: reg_rdata <= {16'h0000, setting_fault_flag, load_status, 1'b0,
                                 operating_condition_code, outs};
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Blocking pin passes two flip-flops, then is latched once per program cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blk_meta_r <= 1'b0;
      blk_sync_r <= 1'b0;
    end else begin
      blk_meta_r <= block_in;
      blk_sync_r <= blk_meta_r;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blk_r <= 1'b0;
      cap_r <= '0;
    end else if (cycle_start) begin
      blk_r <= blk_sync_r; // RULE9
      cap_r <= thermal_cap;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold compares, capacity only.
  assign a1_hit = set_r.alarm1_en && (cap_r >= set_r.first_alarm_threshold); // RULE1 RULE2 RULE5
  assign a2_hit = set_r.alarm2_en && (cap_r >= set_r.second_alarm_threshold); // RULE3 RULE5
  assign inh_hit = set_r.restart_lock_enable && (cap_r >= set_r.restart_lock_threshold); // RULE4 RULE5
  assign trip_pick = set_r.trip_en && (cap_r >= set_r.operate_threshold); // RULE4 RULE5

  // The 5 ms lead time for blocking is the far side's duty; the delay only runs in TIMING.
  tos_delay u_delay (
    .sys_clk(sys_clk),
    .rst(rst),
    .arm(trip_st_r == TOS_TRIP_TIMING),
    .steps(set_r.operate_extra_delay),
    .done(delay_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trip sequencing with blocking.
  always_comb begin
    trip_st_nxt = trip_st_r;
    case (trip_st_r)
      TOS_TRIP_IDLE: begin
        if (trip_pick && blk_r) begin
          trip_st_nxt = TOS_TRIP_BLOCKED; // RULE11
        end else if (trip_pick) begin
          trip_st_nxt = TOS_TRIP_TIMING; // RULE10
        end
      end
      TOS_TRIP_TIMING: begin
        if (!trip_pick || blk_r) begin
          trip_st_nxt = TOS_TRIP_IDLE; // RULE12
        end else if (delay_done) begin
          trip_st_nxt = TOS_TRIP_ACTIVE; // RULE6 RULE7
        end
      end
      TOS_TRIP_ACTIVE: begin
        if (!trip_pick || blk_r) begin
          trip_st_nxt = TOS_TRIP_IDLE; // RULE12
        end
      end
      TOS_TRIP_BLOCKED: begin
        if (!trip_pick || !blk_r) begin
          trip_st_nxt = TOS_TRIP_IDLE;
        end
      end
      default: trip_st_nxt = TOS_TRIP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trip_st_r <= TOS_TRIP_IDLE;
    end else begin
      trip_st_r <= trip_st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and condition code. Highest active stage wins the code.
  always_comb begin
    outs_nxt = '0;
    outs_nxt.alarm1 = a1_hit;
    outs_nxt.alarm2 = a2_hit;
    outs_nxt.restart_lock = inh_hit;
    outs_nxt.trip = (trip_st_nxt == TOS_TRIP_ACTIVE); // RULE6
    outs_nxt.start = (trip_st_nxt == TOS_TRIP_TIMING) || (trip_st_nxt == TOS_TRIP_ACTIVE); // RULE10
    outs_nxt.blocked = (trip_st_nxt == TOS_TRIP_BLOCKED); // RULE11
    if (outs_nxt.blocked) begin
      cond_nxt = TOS_COND_BLOCKED; // RULE14
    end else if (outs_nxt.trip) begin
      cond_nxt = TOS_COND_TRIP;
    end else if (outs_nxt.restart_lock) begin
      cond_nxt = TOS_COND_INHIBIT;
    end else if (outs_nxt.alarm2) begin
      cond_nxt = TOS_COND_ALARM2;
    end else if (outs_nxt.alarm1) begin
      cond_nxt = TOS_COND_ALARM1;
    end else begin
      cond_nxt = TOS_COND_NORMAL;
    end
    if (cond_nxt == TOS_COND_NORMAL) begin
      outs_nxt = '0; // RULE15
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outs <= '0;
      operating_condition_code <= TOS_COND_NORMAL;
    end else begin
      outs <= outs_nxt;
      operating_condition_code <= cond_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load class. Trip limit is nominal scaled by the used service factor.
  assign cur_x100 = (`TOS_CUR_W+7)'(meas_current) * (`TOS_CUR_W+7)'(`TOS_LIGHT_DIV);
  assign nom_x2 = {nominal_current, 1'b0};
  assign trip_limit = `TOS_CUR_W'((32'(nominal_current) * 32'(fix_used.service_factor)) >> `TOS_FIX_FRAC);

  always_comb begin
    if (cur_x100 < (`TOS_CUR_W+7)'(nominal_current)) begin
      load_nxt = TOS_LOAD_LIGHT; // RULE16
    end else if ((`TOS_CUR_W+1)'(meas_current) > nom_x2) begin
      load_nxt = TOS_LOAD_HIGH; // RULE17
    end else if (meas_current > trip_limit) begin
      load_nxt = TOS_LOAD_OVER; // RULE17
    end else begin
      load_nxt = TOS_LOAD_NORMAL; // RULE17
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      load_status <= TOS_LOAD_LIGHT;
    end else begin
      load_status <= load_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Setting checks. A zero factor is invalid; faults drop as soon as fixed.
  always_comb begin
    fix_nxt = fix_raw;
    fault_nxt = '0;
    if (fix_raw.service_factor == '0) begin
      fix_nxt.service_factor = `TOS_FIX_ONE; // RULE18
      fault_nxt.service_fault = 1'b1;
    end
    if (!fix_raw.ambient_valid || fix_raw.ambient_k == '0) begin
      fix_nxt.ambient_k = `TOS_FIX_ONE; // RULE19
      fault_nxt.ambient_fault = 1'b1;
    end
    if (fix_raw.nominal_k == '0) begin
      fix_nxt.nominal_k = `TOS_FIX_ONE; // RULE20
      fault_nxt.nominal_fault = 1'b1;
    end
    fault_nxt.ambient_k_fault = !fix_raw.ambient_k_consistent; // RULE21
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      setting_fault_flag <= '0;
      fix_used <= '0;
    end else begin
      setting_fault_flag <= fault_nxt;
      fix_used <= fix_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  chk_normal_quiet: assert property (@(posedge sys_clk) disable iff (rst) // RULE15
    operating_condition_code == TOS_COND_NORMAL |-> outs == '0)
    else $error("Output active while condition normal.");
  chk_alarm1_disabled: assert property (@(posedge sys_clk) disable iff (rst) // RULE5
    !set_r.alarm1_en |=> !outs.alarm1)
    else $error("Alarm 1 asserted while disabled.");
  chk_alarm1_level: assert property (@(posedge sys_clk) disable iff (rst) // RULE2
    set_r.alarm1_en && cap_r >= set_r.first_alarm_threshold |=> outs.alarm1)
    else $error("Alarm 1 missed its threshold.");
  chk_alarm2_level: assert property (@(posedge sys_clk) disable iff (rst) // RULE3
    set_r.alarm2_en && cap_r >= set_r.second_alarm_threshold |=> outs.alarm2)
    else $error("Alarm 2 missed its threshold.");
  chk_inhibit_level: assert property (@(posedge sys_clk) disable iff (rst) // RULE4
    outs.restart_lock |-> $past(cap_r) >= $past(set_r.restart_lock_threshold))
    else $error("Inhibit asserted below threshold.");
  chk_trip_nodelay: assert property (@(posedge sys_clk) disable iff (rst) // RULE7
    trip_st_r == TOS_TRIP_TIMING && set_r.operate_extra_delay == '0 && trip_pick && !blk_r |=> outs.trip)
    else $error("Trip delayed with zero delay setting.");
  chk_block_stop: assert property (@(posedge sys_clk) disable iff (rst) // RULE11
    trip_st_r == TOS_TRIP_IDLE && trip_pick && blk_r |=> outs.blocked && !outs.start && !outs.trip)
    else $error("Blocked pick-up went on to operate.");
  chk_block_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE12
    outs.start && blk_r |=> !outs.start ##1 !outs.trip)
    else $error("Start not cleared by blocking.");
  chk_block_sample: assert property (@(posedge sys_clk) disable iff (rst) // RULE9
    !cycle_start |=> $stable(blk_r))
    else $error("Blocking changed outside cycle start.");
  chk_sf_fault: assert property (@(posedge sys_clk) disable iff (rst) // RULE18
    fix_raw.service_factor == '0 |=> setting_fault_flag.service_fault && fix_used.service_factor == `TOS_FIX_ONE)
    else $error("Service factor fault not handled.");
endmodule

// >>> verif/tos_image_model.sv
// Purpose: Thermal image and blocking matrix stand-in for the overload stage.
// Assumes: Levels requested by the bench are handed out on sys_clk.
// Notes: PERIOD sets the program cycle length; a longer PERIOD gives a slower image.
`timescale 1ns/1ps
`include "tos_defs.svh"
module tos_image_model #(
  parameter int PERIOD = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Requested levels from the bench.
  input wire logic [`TOS_THR_W-1:0] cap_level,
  input wire logic [`TOS_CUR_W-1:0] cur_level,
  input wire logic [`TOS_CUR_W-1:0] nom_level,
  input wire logic blk_level,
  // Towards the stage.
  output logic cycle_start,
  output logic [`TOS_THR_W-1:0] thermal_cap,
  output logic [`TOS_CUR_W-1:0] meas_current,
  output logic [`TOS_CUR_W-1:0] nominal_current,
  output logic block_in
);
  logic [7:0] tick_r;
  ////////////////////////////////////////////////////////////////////////////////
  // One pulse per program cycle; the image refreshes its value on that pulse.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick_r <= 8'h00;
      cycle_start <= 1'b0;
    end else begin
      tick_r <= (tick_r == 8'(PERIOD - 1)) ? 8'h00 : tick_r + 8'h01;
      cycle_start <= (tick_r == 8'h00);
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      thermal_cap <= '0;
    end else if (tick_r == 8'h00) begin
      thermal_cap <= cap_level;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Blocking follows the bench level one clock later, so it always lands long before
  // any nonzero operate delay could run out.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      block_in <= 1'b0;
      meas_current <= '0;
      nominal_current <= '0;
    end else begin
      block_in <= blk_level;
      meas_current <= cur_level;
      nominal_current <= nom_level;
    end
  end
endmodule

// >>> verif/tb_thermal_overload_stage_logic.sv
// Purpose: Self-checking bench for the thermal overload stage decision logic.
// Assumes: Program cycle of 8 clocks from the image model; 40 MHz clock.
// Notes: One operate step is 200000 clocks, so nonzero delays are only seen pending.
`timescale 1ns/1ps
`include "tos_defs.svh"
module tb_thermal_overload_stage_logic;
  import tos_pkg::*;
  logic sys_clk, rst, cycle_start, block_in, reg_wr, reg_rd, blk_level;
  logic [`TOS_THR_W-1:0] thermal_cap, cap_level;
  logic [`TOS_CUR_W-1:0] meas_current, nominal_current, cur_level, nom_level;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd;
  tos_fix_s fix_raw, fix_used;
  tos_out_s outs;
  tos_cond_e operating_condition_code;
  tos_load_e load_status;
  tos_fault_s setting_fault_flag;
  int bad_count, num_checks;
  tos_image_model #(.PERIOD(8)) u_tos_image_model (.sys_clk(sys_clk), .rst(rst), .cap_level(cap_level),
    .cur_level(cur_level), .nom_level(nom_level), .blk_level(blk_level), .cycle_start(cycle_start),
    .thermal_cap(thermal_cap), .meas_current(meas_current), .nominal_current(nominal_current), .block_in(block_in));
  tos_stage u_tos_stage (.sys_clk(sys_clk), .rst(rst), .cycle_start(cycle_start), .thermal_cap(thermal_cap),
    .meas_current(meas_current), .nominal_current(nominal_current), .block_in(block_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fix_raw(fix_raw),
    .outs(outs), .operating_condition_code(operating_condition_code), .load_status(load_status),
    .setting_fault_flag(setting_fault_flag), .fix_used(fix_used));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask
  // Thirty clocks, almost four program cycles of 8, long enough for every path.
  task automatic drive(input int cap, input logic blk);
    @(posedge sys_clk);
    cap_level <= cap[`TOS_THR_W-1:0];
    blk_level <= blk;
    repeat (30) @(posedge sys_clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_reset();
    logic [31:0] dflt [6] = '{32'h0, `TOS_A1_DEF, `TOS_A2_DEF, `TOS_INH_DEF, `TOS_TRIP_DEF, 32'h0};
    for (int i = 0; i < 6; i++) begin
      reg_read(i[3:0]);
      check_word("reset_reg", dflt[i], rd);
    end
    reg_read(4'h7);
    check_word("unmapped_read", 32'h0, rd);
    drive(1500, 1'b0);
    check_word("disabled_outs", 32'h0, outs);
    check_word("disabled_cond", TOS_COND_NORMAL, operating_condition_code);
  endtask
  task automatic test_levels();
    int caps [6] = '{399, 400, 799, 800, 999, 1000};
    logic [5:0] eo [6] = '{6'h00, 6'h30, 6'h30, 6'h38, 6'h38, 6'h3E};
    tos_cond_e ec [6] = '{TOS_COND_NORMAL, TOS_COND_ALARM2, TOS_COND_ALARM2, TOS_COND_INHIBIT,
      TOS_COND_INHIBIT, TOS_COND_TRIP};
    logic [5:0] one [4] = '{6'h20, 6'h10, 6'h08, 6'h04};
    tos_cond_e c1 [4] = '{TOS_COND_ALARM1, TOS_COND_ALARM2, TOS_COND_INHIBIT, TOS_COND_TRIP};
    reg_write(4'h0, 32'hF);
    for (int i = 0; i < 6; i++) begin
      drive(caps[i], 1'b0);
      check_word("level_outs", eo[i], outs);
      check_word("level_cond", ec[i], operating_condition_code);
    end
    reg_read(4'h6);
    check_word("status_word", {23'h0, TOS_COND_TRIP, 6'h3E}, {23'h0, rd[8:0]});
    for (int i = 0; i < 4; i++) begin
      reg_write(4'h0, 32'h1 << i);
      drive(1000, 1'b0);
      check_word("single_enable", one[i][5:2], outs[5:2]);
      check_word("single_cond", c1[i], operating_condition_code);
    end
  endtask
  task automatic test_change();
    reg_write(4'h0, 32'hF);
    drive(450, 1'b0);
    reg_write(4'h1, 32'd500);
    drive(450, 1'b0);
    check_flag("alarm1_after_change", 1'b0, outs.alarm1);
    check_flag("alarm2_kept", 1'b1, outs.alarm2);
    reg_write(4'h1, 32'h5DD);
    reg_read(4'h1);
    check_word("refused_threshold", 32'd500, rd);
    reg_write(4'h1, 32'd400);
  endtask
  task automatic test_block();
    drive(1000, 1'b0);
    drive(1000, 1'b1);
    check_word("block_after_start", 3'b001, {outs.trip, outs.start, outs.blocked});
    check_word("block_cond", TOS_COND_BLOCKED, operating_condition_code);
    drive(1000, 1'b0);
    check_word("block_released", 3'b110, {outs.trip, outs.start, outs.blocked});
    drive(0, 1'b1);
    drive(1000, 1'b1);
    check_word("pickup_blocked", 3'b001, {outs.trip, outs.start, outs.blocked});
  endtask
  task automatic test_delay();
    drive(0, 1'b0);
    reg_write(4'h5, 32'h1);
    drive(1000, 1'b0);
    check_word("trip_pending", 2'b01, {outs.trip, outs.start});
    reg_write(4'h5, 32'h0);
    drive(1000, 1'b0);
    check_word("trip_no_delay", 2'b11, {outs.trip, outs.start});
  endtask
  task automatic test_load();
    int cur [6] = '{9, 10, 1100, 1300, 2000, 2001};
    tos_load_e el [6] = '{TOS_LOAD_LIGHT, TOS_LOAD_NORMAL, TOS_LOAD_NORMAL, TOS_LOAD_OVER, TOS_LOAD_OVER,
      TOS_LOAD_HIGH};
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      cur_level <= cur[i][`TOS_CUR_W-1:0];
      drive(0, 1'b0);
      check_word("load_class", el[i], load_status);
    end
  endtask
  // Good raw values are 1.25 so that a substituted 1.0 is visible.
  task automatic test_faults();
    tos_fix_s bad [4] = '{{16'h0, 16'h0500, 16'h0500, 1'b1, 1'b1}, {16'h0500, 16'h0500, 16'h0500, 1'b0, 1'b1},
      {16'h0500, 16'h0500, 16'h0, 1'b1, 1'b1}, {16'h0500, 16'h0500, 16'h0500, 1'b1, 1'b0}};
    logic [47:0] eu [4] = '{48'h040005000500, 48'h050004000500, 48'h050005000400, 48'h050005000500};
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      fix_raw <= bad[i];
      drive(0, 1'b0);
      check_word("fault_flags", 4'h8 >> i, setting_fault_flag);
      check_word("used_fix", eu[i][47:16], fix_used[49:18]);
      check_word("used_nominal", eu[i][15:0], fix_used[17:2]);
      reg_read(4'h6);
      check_word("status_faults", 4'h8 >> i, rd[15:12]);
    end
    @(posedge sys_clk);
    fix_raw <= {16'h0500, 16'h0500, 16'h0500, 1'b1, 1'b1};
    drive(0, 1'b0);
    check_word("faults_gone", 4'h0, setting_fault_flag);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    bad_count = 0;
    num_checks = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    cap_level = '0;
    blk_level = 1'b0;
    cur_level = '0;
    nom_level = 16'd1000;
    fix_raw = {16'h0500, 16'h0500, 16'h0500, 1'b1, 1'b1};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_levels();
    test_change();
    test_block();
    test_delay();
    test_load();
    test_faults();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end
endmodule
